//--- elfe_pkg.sv
// shared constants for the event log and filter engine
package elfe_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int TS_PERIOD_S = 1;
  localparam int TS_TICK_CYCLES = TS_PERIOD_S * CLK_HZ;
  localparam int ACT_DELAY_CYCLES = 250;
  localparam logic [31:0] TS_RESET = 32'h0000_0000;
  localparam logic [32:0] TS_REL_LIMIT = 33'h1_4000_0000;
  localparam int LOG_DEPTH = 92;
  localparam logic [6:0] LOG_LAST = 7'h5b;
  localparam logic [6:0] LOG_FULL = 7'h5c;
  localparam int LOG_W = 48;
  localparam int SDR_BYTES = 2176;
  localparam logic [11:0] SDR_LAST = 12'h87f;
  localparam logic [7:0] REC_THRESH = 8'h01;
  localparam logic [7:0] REC_FULL_DISC = 8'h02;
  localparam logic [7:0] REC_COMPACT = 8'h03;
  localparam logic [3:0] THR_LAST_IDX = 4'h8;
  localparam logic [3:0] EVT_LAST_IDX = 4'h4;
  localparam int FILT_N = 30;
  localparam int FILT_W = 27;
  localparam int F_TYPE_LSB = 19;
  localparam int F_MASK_LSB = 11;
  localparam int F_ACT_LSB = 4;
  localparam int F_EN_BIT = 31;
  localparam logic [7:0] TYPE_ANY = 8'hff;
  localparam logic [31:0] ALERT_POLICY = 32'h0000_0001;
  localparam int A_PDOWN = 0;
  localparam int A_SOFT = 1;
  localparam int A_CYCLE = 2;
  localparam int A_RESET = 3;
  localparam int A_DIAG = 4;
  localparam int A_TRAP = 5;
  localparam int A_BUSMSG = 6;
  localparam logic [3:0] RANK_EXPEDITED = 4'h0;
  localparam logic [3:0] RANK_PDOWN = 4'h1;
  localparam logic [3:0] RANK_SOFT = 4'h2;
  localparam logic [3:0] RANK_CYCLE = 4'h3;
  localparam logic [3:0] RANK_RESET = 4'h4;
  localparam logic [3:0] RANK_DIAG = 4'h5;
  localparam logic [3:0] RANK_TRAP = 4'h6;
  localparam logic [3:0] RANK_BUSMSG = 4'h8;
  localparam logic [3:0] RANK_NONE = 4'hf;
  localparam logic [3:0] OP_LOG_INFO = 4'h0;
  localparam logic [3:0] OP_LOG_GET = 4'h1;
  localparam logic [3:0] OP_LOG_ADD = 4'h2;
  localparam logic [3:0] OP_LOG_CLEAR = 4'h3;
  localparam logic [3:0] OP_TIME_GET = 4'h4;
  localparam logic [3:0] OP_TIME_SET = 4'h5;
  localparam logic [3:0] OP_SDR_TIME_GET = 4'h6;
  localparam logic [3:0] OP_SDR_READ = 4'h7;
  localparam logic [3:0] OP_SDR_WRITE = 4'h8;
  localparam logic [3:0] OP_FILT_WRITE = 4'h9;
  localparam logic [3:0] OP_FILT_READ = 4'ha;
  localparam logic [3:0] OP_POLICY_READ = 4'hb;
  localparam logic [3:0] OP_EVENT_MSG = 4'hc;
endpackage

//--- elfe_sec_tick.sv
// once-per-second prescaler for the timestamp counter
`timescale 1ns/100ps
module elfe_sec_tick import elfe_pkg::*; #(
  parameter int TICK_CYCLES = TS_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } elfe_tick_t;

  elfe_tick_t r;
  elfe_tick_t n;

  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (restart) begin
      // a freshly written time waits a whole second before its first step
      n.cnt = '0;
    end else if (r.cnt == LAST) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;
endmodule

//--- elfe_core.sv
// event log, timestamp, sensor record store, init agent and event filter
`timescale 1ns/100ps
module elfe_core import elfe_pkg::*; #(
  parameter int TICK_CYCLES = TS_TICK_CYCLES,
  parameter int ACT_DELAY = ACT_DELAY_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic [11:0] cmd_addr,
  input wire logic [31:0] cmd_data,
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [31:0] rsp_data,
  input wire logic int_evt_valid,
  input wire logic [15:0] int_evt_data,
  output logic int_evt_ready,
  input wire logic sys_boot,
  output logic scan_busy,
  output logic cfg_valid,
  output logic [7:0] cfg_sensor,
  output logic [3:0] cfg_index,
  output logic [7:0] cfg_value,
  output logic act_now_valid,
  output logic [6:0] act_now_vec,
  output logic [3:0] act_rank,
  output logic act_dly_valid,
  output logic [3:0] act_dly_vec,
  output logic [31:0] timestamp,
  output logic ts_relative
);
  localparam int DW = $clog2(ACT_DELAY + 1);

  typedef enum logic [0:0] {ST_IDLE, ST_SCAN} elfe_state_t;

  typedef struct packed {
    elfe_state_t st;
    logic [6:0] wr_ptr;
    logic [6:0] count;
    logic [31:0] ts;
    logic rsp_valid;
    logic rsp_ok;
    logic [31:0] rsp_data;
    logic [FILT_N-1:0] filt_en;
    logic [11:0] scan_addr;
    logic [7:0] scan_type;
    logic [7:0] scan_sensor;
    logic cfg_valid;
    logic [7:0] cfg_sensor;
    logic [3:0] cfg_index;
    logic [7:0] cfg_value;
    logic now_valid;
    logic [6:0] now_vec;
    logic [3:0] rank;
    logic [3:0] pend;
    logic [DW-1:0] dly_cnt;
    logic dly_valid;
    logic [3:0] dly_vec;
    logic boot_s1;
    logic boot_s2;
    logic boot_s3;
  } elfe_reg_t;

  elfe_reg_t r;
  elfe_reg_t n;

  logic [LOG_W-1:0] log_mem [LOG_DEPTH];
  logic [7:0] sdr_mem [SDR_BYTES];
  logic [FILT_W-1:0] filt_mem [FILT_N];

  logic tick;
  logic cmd_fire;
  logic cmd_evt;
  logic cmd_add;
  logic cmd_logw;
  logic int_take;
  logic evt_take;
  logic [15:0] evt_data;
  logic log_we;
  logic sdr_we;
  logic filt_we;
  logic set_time;
  logic [FILT_N-1:0] hit;
  logic [6:0] sel;
  logic [3:0] expd;
  logic [6:0] sup;
  logic [3:0] dly_new;
  logic [3:0] pend_m;
  logic [6:0] pend_s;

  // a filter entry fires when enabled, type matches and any offset class overlaps
  function automatic logic entry_hit(logic [FILT_W-1:0] e, logic [15:0] ev);
    logic [7:0] ty;
    ty = e[F_TYPE_LSB +: 8];
    return ((ty == TYPE_ANY) || (ty == ev[15:8])) && ((e[F_MASK_LSB +: 8] & ev[7:0]) != 8'h00);
  endfunction

  // best rank wins; expedited delayed actions outrank everything else
  function automatic logic [3:0] top_rank(logic [6:0] v, logic [3:0] ex);
    if ((v[3:0] & ex) != 4'h0) return RANK_EXPEDITED;
    if (v[A_PDOWN]) return RANK_PDOWN;
    if (v[A_SOFT]) return RANK_SOFT;
    if (v[A_CYCLE]) return RANK_CYCLE;
    if (v[A_RESET]) return RANK_RESET;
    if (v[A_DIAG]) return RANK_DIAG;
    if (v[A_TRAP]) return RANK_TRAP;
    if (v[A_BUSMSG]) return RANK_BUSMSG;
    return RANK_NONE;
  endfunction

  // power-down wins over the actions it would make pointless
  function automatic logic [6:0] suppress(logic [6:0] v);
    logic [6:0] o;
    o = v;
    if (v[A_PDOWN]) begin
      o[A_SOFT] = 1'b0;
      o[A_CYCLE] = 1'b0;
      o[A_RESET] = 1'b0;
      o[A_DIAG] = 1'b0;
    end
    return o;
  endfunction

  elfe_sec_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .restart(set_time),
    .tick(tick)
  );

  assign cmd_ready = (r.st == ST_IDLE);
  assign cmd_fire = cmd_valid && cmd_ready;
  assign cmd_evt = cmd_fire && (cmd_op == OP_EVENT_MSG);
  assign cmd_add = cmd_fire && (cmd_op == OP_LOG_ADD);
  assign cmd_logw = cmd_evt || cmd_add || (cmd_fire && (cmd_op == OP_LOG_CLEAR));
  // commands own the log port; internal events wait for every cycle in which a command writes the log
  assign int_evt_ready = !cmd_logw;
  assign int_take = int_evt_valid && !cmd_logw;
  assign evt_take = cmd_evt || int_take;
  assign evt_data = (cmd_evt || cmd_add) ? cmd_data[15:0] : int_evt_data;
  assign log_we = evt_take || cmd_add;
  assign set_time = cmd_fire && (cmd_op == OP_TIME_SET);
  assign sdr_we = cmd_fire && (cmd_op == OP_SDR_WRITE) && (cmd_addr <= SDR_LAST);
  assign filt_we = cmd_fire && (cmd_op == OP_FILT_WRITE) && (cmd_addr < 12'(FILT_N));

  genvar g;
  generate
    for (g = 0; g < FILT_N; g++) begin : g_match
      assign hit[g] = r.filt_en[g] && entry_hit(filt_mem[g], evt_data);
    end
  endgenerate

  always_comb begin
    sel = 7'h00;
    expd = 4'h0;
    for (int i = 0; i < FILT_N; i++) begin
      if (hit[i]) begin
        sel = sel | filt_mem[i][F_ACT_LSB +: 7];
        expd = expd | filt_mem[i][3:0];
      end
    end
  end

  assign sup = suppress(sel);
  assign dly_new = sup[3:0] & ~expd;
  // merged pending set is filtered again so a later power-down still wins
  assign pend_s = suppress({3'h0, r.pend | dly_new});
  assign pend_m = pend_s[3:0];

  always_comb begin
    n = r;
    n.rsp_valid = 1'b0;
    n.cfg_valid = 1'b0;
    n.now_valid = 1'b0;
    n.dly_valid = 1'b0;
    n.boot_s1 = sys_boot;
    n.boot_s2 = r.boot_s1;
    n.boot_s3 = r.boot_s2;
    if (tick) begin
      n.ts = r.ts + 32'h1;
    end
    if (log_we) begin
      n.wr_ptr = (r.wr_ptr == LOG_LAST) ? 7'h00 : r.wr_ptr + 7'h1;
      n.count = (r.count == LOG_FULL) ? LOG_FULL : r.count + 7'h1;
    end
    if (r.pend != 4'h0) begin
      if (r.dly_cnt == DW'(1)) begin
        n.dly_valid = 1'b1;
        n.dly_vec = r.pend;
        n.pend = 4'h0;
      end else begin
        n.dly_cnt = r.dly_cnt - DW'(1);
      end
    end
    if (evt_take) begin
      // alerts and expedited actions leave in the cycle after detection
      n.now_valid = (sup[6:4] != 3'h0) || ((sup[3:0] & expd) != 4'h0);
      n.now_vec = {sup[6:4], sup[3:0] & expd};
      n.rank = top_rank(sup, expd);
      if (dly_new != 4'h0) begin
        n.pend = (n.pend == 4'h0) ? dly_new : pend_m;
        if (n.pend == dly_new) begin
          n.dly_cnt = DW'(ACT_DELAY);
        end
      end
    end
    unique case (r.st)
      ST_SCAN: begin
        // fixed 16-byte slots: type, sensor, then settings bytes
        unique case (r.scan_addr[3:0])
          4'h0: n.scan_type = sdr_mem[r.scan_addr];
          4'h1: n.scan_sensor = sdr_mem[r.scan_addr];
          default: begin
            if (((r.scan_type == REC_THRESH) && (r.scan_addr[3:0] <= THR_LAST_IDX)) ||
                (((r.scan_type == REC_FULL_DISC) || (r.scan_type == REC_COMPACT)) &&
                 (r.scan_addr[3:0] <= EVT_LAST_IDX))) begin
              n.cfg_valid = 1'b1;
              n.cfg_sensor = r.scan_sensor;
              n.cfg_index = r.scan_addr[3:0];
              n.cfg_value = sdr_mem[r.scan_addr];
            end
          end
        endcase
        if (r.scan_addr == SDR_LAST) begin
          n.st = ST_IDLE;
        end else begin
          n.scan_addr = r.scan_addr + 12'h1;
        end
      end
      ST_IDLE: begin
        if (cmd_fire) begin
          n.rsp_valid = 1'b1;
          n.rsp_ok = 1'b1;
          n.rsp_data = 32'h0000_0000;
          unique case (cmd_op)
            OP_LOG_INFO: n.rsp_data = {9'h000, r.wr_ptr, 9'h000, r.count};
            OP_LOG_GET: begin
              if (cmd_addr[6:0] <= LOG_LAST) begin
                n.rsp_data = cmd_addr[7] ? log_mem[cmd_addr[6:0]][47:16]
                                         : {16'h0000, log_mem[cmd_addr[6:0]][15:0]};
              end else begin
                n.rsp_ok = 1'b0;
              end
            end
            OP_LOG_ADD, OP_EVENT_MSG: n.rsp_data = {25'h0000000, r.wr_ptr};
            OP_LOG_CLEAR: begin
              n.wr_ptr = 7'h00;
              n.count = 7'h00;
            end
            OP_TIME_GET, OP_SDR_TIME_GET: n.rsp_data = r.ts;
            OP_TIME_SET: n.ts = cmd_data;
            OP_SDR_READ: begin
              n.rsp_ok = (cmd_addr <= SDR_LAST);
              n.rsp_data = n.rsp_ok ? {24'h000000, sdr_mem[cmd_addr]} : 32'h0000_0000;
            end
            OP_SDR_WRITE: n.rsp_ok = sdr_we;
            OP_FILT_WRITE: begin
              n.rsp_ok = filt_we;
              if (filt_we) begin
                n.filt_en[cmd_addr[4:0]] = cmd_data[F_EN_BIT];
              end
            end
            OP_FILT_READ: begin
              n.rsp_ok = (cmd_addr < 12'(FILT_N));
              if (n.rsp_ok) begin
                n.rsp_data = {r.filt_en[cmd_addr[4:0]], 4'h0, filt_mem[cmd_addr[4:0]]};
              end
            end
            OP_POLICY_READ: n.rsp_data = ALERT_POLICY;
            default: n.rsp_ok = 1'b0;
          endcase
        end
      end
    endcase
    // a boot restarts the scan from the first byte, even mid-scan
    if (r.boot_s2 && !r.boot_s3) begin
      n.st = ST_SCAN;
      n.scan_addr = 12'h000;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.st <= ST_SCAN;
      r.ts <= TS_RESET;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge core_clk) begin
    if (log_we) begin
      log_mem[r.wr_ptr] <= {r.ts, evt_data};
    end
    if (sdr_we) begin
      sdr_mem[cmd_addr] <= cmd_data[7:0];
    end
    if (filt_we) begin
      filt_mem[cmd_addr[4:0]] <= cmd_data[FILT_W-1:0];
    end
  end

  assign rsp_valid = r.rsp_valid;
  assign rsp_ok = r.rsp_ok;
  assign rsp_data = r.rsp_data;
  assign scan_busy = (r.st == ST_SCAN);
  assign cfg_valid = r.cfg_valid;
  assign cfg_sensor = r.cfg_sensor;
  assign cfg_index = r.cfg_index;
  assign cfg_value = r.cfg_value;
  assign act_now_valid = r.now_valid;
  assign act_now_vec = r.now_vec;
  assign act_rank = r.rank;
  assign act_dly_valid = r.dly_valid;
  assign act_dly_vec = r.dly_vec;
  assign timestamp = r.ts;
  assign ts_relative = ({1'b0, r.ts} <= TS_REL_LIMIT);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  log_depth_a: assert property (r.count <= LOG_FULL)
    else $error("log count above depth");
  log_wrap_a: assert property (log_we && r.wr_ptr == LOG_LAST |=> r.wr_ptr == 7'h00)
    else $error("log pointer did not wrap to first slot");
  log_clear_a: assert property (cmd_fire && cmd_op == OP_LOG_CLEAR |=> r.count == 7'h00)
    else $error("clear left entries");
  ts_step_a: assert property (tick && !set_time |=> r.ts == $past(r.ts) + 32'h1)
    else $error("timestamp did not step");
  ts_hold_a: assert property (!tick && !set_time |=> $stable(r.ts))
    else $error("timestamp moved without a tick");
  ts_load_a: assert property (set_time |=> r.ts == $past(cmd_data) ##1
    ($past(set_time) || r.ts == $past(r.ts)))
    else $error("set time not kept");
  evt_log_a: assert property (evt_take && r.count < LOG_FULL |=> r.count == $past(r.count) + 7'h1)
    else $error("event not logged");
  pdown_sup_a: assert property (act_dly_valid && act_dly_vec[A_PDOWN] |-> act_dly_vec[3:1] == 3'h0)
    else $error("power-down did not suppress");
  alert_now_a: assert property (evt_take && sup[A_TRAP] |=> act_now_valid && act_now_vec[A_TRAP])
    else $error("trap alert not immediate");
  boot_scan_a: assert property ($rose(r.boot_s2) |=> scan_busy && r.scan_addr == 12'h000)
    else $error("boot did not start scan");
endmodule

//--- elfe_host_model.sv
// host command source model for the event log and filter engine
`timescale 1ns/100ps
module elfe_host_model (
  input wire logic core_clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [31:0] rsp_data,
  output logic cmd_valid,
  output logic [3:0] cmd_op,
  output logic [11:0] cmd_addr,
  output logic [31:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_addr = 12'h000;
    cmd_data = 32'h0000_0000;
  end

  // request held until taken; released lines show the inverse so stale values never match
  task automatic cmd(input logic [3:0] op, input logic [11:0] a, input logic [31:0] d,
      output logic v, output logic ok, output logic [31:0] rd);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    v = rsp_valid;
    ok = rsp_ok;
    rd = rsp_data;
    cmd_valid = 1'b0;
    cmd_op = ~op;
    cmd_addr = ~a;
    cmd_data = ~d;
  endtask
endmodule

//--- elfe_core_test.sv
// self-checking testbench for the event log and filter engine core
`timescale 1ns/100ps
module elfe_core_test import elfe_pkg::*;;
  localparam int TICKS = 10;
  localparam int DLY = 4;
  localparam int LIMIT = 20000;
  logic core_clk, reset, cmd_valid, cmd_ready, rsp_valid, rsp_ok;
  logic [3:0] cmd_op;
  logic [11:0] cmd_addr;
  logic [31:0] cmd_data, rsp_data, timestamp, rd;
  logic int_evt_valid, int_evt_ready, sys_boot, scan_busy, cfg_valid;
  logic [15:0] int_evt_data;
  logic [7:0] cfg_sensor, cfg_value;
  logic [3:0] cfg_index, act_rank, act_dly_vec;
  logic act_now_valid, act_dly_valid, ts_relative, v, ok;
  logic [6:0] act_now_vec;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  elfe_core #(.TICK_CYCLES(TICKS), .ACT_DELAY(DLY)) dut_u (.core_clk(core_clk),
    .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_data(rsp_data), .int_evt_valid(int_evt_valid), .int_evt_data(int_evt_data),
    .int_evt_ready(int_evt_ready), .sys_boot(sys_boot), .scan_busy(scan_busy),
    .cfg_valid(cfg_valid), .cfg_sensor(cfg_sensor), .cfg_index(cfg_index),
    .cfg_value(cfg_value), .act_now_valid(act_now_valid), .act_now_vec(act_now_vec),
    .act_rank(act_rank), .act_dly_valid(act_dly_valid), .act_dly_vec(act_dly_vec),
    .timestamp(timestamp), .ts_relative(ts_relative));

  elfe_host_model host_u (.core_clk(core_clk), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic run(input logic [3:0] op, input logic [11:0] a, input logic [31:0] d,
      input logic exp_ok);
    host_u.cmd(op, a, d, v, ok, rd);
    check("rsp_valid", 32'(v), 32'h1);
    check("rsp_ok", 32'(ok), 32'(exp_ok));
  endtask

  task automatic wait_dly(input logic [3:0] exp);
    int n;
    n = 0;
    while (act_dly_valid !== 1'b1 && n < DLY + 4) begin
      @(negedge core_clk);
      n++;
    end
    check("act_dly_valid", 32'(act_dly_valid), 32'h1);
    check("act_dly_vec", 32'(act_dly_vec), 32'(exp));
  endtask

  function automatic logic [31:0] fent(input logic [7:0] ty, input logic [6:0] act,
      input logic [3:0] ex);
    return {1'b1, 4'h0, ty, 8'hff, act, ex};
  endfunction

  task automatic t_time();
    run(OP_TIME_SET, 12'h000, 32'h1234_5678, 1'b1);
    check("timestamp", timestamp, 32'h1234_5678);
    check("ts_relative", 32'(ts_relative), 32'h1);
    repeat (5) @(negedge core_clk);
    run(OP_TIME_GET, 12'h000, 32'h0, 1'b1);
    check("time get", rd, 32'h1234_5678);
    repeat (8) @(negedge core_clk);
    run(OP_SDR_TIME_GET, 12'h000, 32'h0, 1'b1);
    check("store time", rd, 32'h1234_5679);
    repeat (10) @(negedge core_clk);
    check("timestamp", timestamp, 32'h1234_567a);
    run(OP_TIME_SET, 12'h000, 32'hffff_ffff, 1'b1);
    repeat (15) @(negedge core_clk);
    check("wrap", timestamp, 32'h0);
  endtask

  task automatic t_log();
    run(OP_LOG_CLEAR, 12'h000, 32'h0, 1'b1);
    for (int i = 0; i <= LOG_DEPTH; i++) begin
      run(OP_LOG_ADD, 12'h000, 32'h0000_a000 | 32'(i), 1'b1);
      check("log slot", rd, 32'(i % LOG_DEPTH));
    end
    run(OP_LOG_GET, 12'h000, 32'h0, 1'b1);
    check("slot 0", 32'(rd[15:0]), 32'h0000_a05c);
    run(OP_LOG_GET, {5'h0, LOG_LAST}, 32'h0, 1'b1);
    check("last slot", 32'(rd[15:0]), 32'h0000_a05b);
    run(OP_LOG_GET, {5'h0, LOG_FULL}, 32'h0, 1'b0);
    run(OP_LOG_CLEAR, 12'h000, 32'h0, 1'b1);
    run(OP_TIME_SET, 12'h000, 32'h0000_0100, 1'b1);
    run(OP_LOG_ADD, 12'h000, 32'h0000_0001, 1'b1);
    check("after clear", rd, 32'h0);
    run(OP_LOG_GET, 12'h080, 32'h0, 1'b1);
    check("entry time", rd, 32'h0000_0100);
    run(OP_LOG_INFO, 12'h000, 32'h0, 1'b1);
    check("log info", rd, 32'h0001_0001);
  endtask

  task automatic t_ranks();
    logic [3:0] rk [7] = '{RANK_PDOWN, RANK_SOFT, RANK_CYCLE, RANK_RESET, RANK_DIAG,
      RANK_TRAP, RANK_BUSMSG};
    run(OP_LOG_CLEAR, 12'h000, 32'h0, 1'b1);
    for (int a = 0; a < 7; a++) begin
      run(OP_FILT_WRITE, 12'h000, fent(TYPE_ANY, 7'(1 << a), 4'h0), 1'b1);
      run(OP_EVENT_MSG, 12'h000, 32'h0000_0501, 1'b1);
      check("act_rank", 32'(act_rank), 32'(rk[a]));
      check("act_now_valid", 32'(act_now_valid), 32'(a > 3));
      if (a > 3) begin
        check("act_now_vec", 32'(act_now_vec), 32'(1 << a));
      end else begin
        wait_dly(4'(1 << a));
      end
    end
    run(OP_LOG_GET, 12'h000, 32'h0, 1'b1);
    check("logged event", 32'(rd[15:0]), 32'h0000_0501);
  endtask

  task automatic t_union();
    run(OP_FILT_WRITE, 12'h000, fent(TYPE_ANY, 7'h20, 4'h0), 1'b1);
    run(OP_FILT_WRITE, 12'h01d, fent(8'h05, 7'h1f, 4'h0), 1'b1);
    run(OP_FILT_WRITE, 12'h01e, 32'h0, 1'b0);
    run(4'hd, 12'h000, 32'h0, 1'b0);
    run(OP_POLICY_READ, 12'h000, 32'h0, 1'b1);
    check("policy", rd, ALERT_POLICY);
    run(OP_EVENT_MSG, 12'h000, 32'h0000_0501, 1'b1);
    check("act_now_valid", 32'(act_now_valid), 32'h1);
    check("act_now_vec", 32'(act_now_vec), 32'h20);
    check("act_rank", 32'(act_rank), 32'(RANK_PDOWN));
    wait_dly(4'h1);
    run(OP_EVENT_MSG, 12'h000, 32'h0000_0601, 1'b1);
    check("act_rank", 32'(act_rank), 32'(RANK_TRAP));
  endtask

  task automatic t_internal();
    @(negedge core_clk);
    int_evt_valid = 1'b1;
    int_evt_data = 16'h0701;
    check("int_evt_ready", 32'(int_evt_ready), 32'h1);
    @(negedge core_clk);
    int_evt_valid = 1'b0;
    int_evt_data = 16'hf8fe;
    check("act_now_valid", 32'(act_now_valid), 32'h1);
    check("act_now_vec", 32'(act_now_vec), 32'h20);
  endtask

  task automatic t_expedite();
    run(OP_FILT_WRITE, 12'h000, 32'h0, 1'b1);
    run(OP_FILT_WRITE, 12'h01d, fent(8'h05, 7'h08, 4'h8), 1'b1);
    run(OP_EVENT_MSG, 12'h000, 32'h0000_0501, 1'b1);
    check("act_now_valid", 32'(act_now_valid), 32'h1);
    check("act_now_vec", 32'(act_now_vec), 32'h08);
    check("act_rank", 32'(act_rank), 32'(RANK_EXPEDITED));
    repeat (DLY + 4) @(negedge core_clk);
  endtask

  task automatic t_boot();
    int n;
    n = 0;
    run(OP_SDR_WRITE, 12'h000, 32'(REC_THRESH), 1'b1);
    run(OP_SDR_WRITE, 12'h001, 32'h42, 1'b1);
    for (int i = 2; i <= 8; i++) begin
      run(OP_SDR_WRITE, 12'(i), 32'(i + 16), 1'b1);
    end
    run(OP_SDR_WRITE, 12'h010, 32'(REC_COMPACT), 1'b1);
    run(OP_SDR_WRITE, 12'h011, 32'h43, 1'b1);
    for (int i = 2; i <= 4; i++) begin
      run(OP_SDR_WRITE, 12'(16 + i), 32'(i + 32), 1'b1);
    end
    run(OP_SDR_WRITE, 12'h880, 32'h0, 1'b0);
    run(OP_SDR_READ, 12'h880, 32'h0, 1'b0);
    run(OP_SDR_READ, 12'h001, 32'h0, 1'b1);
    check("record byte", rd, 32'h42);
    sys_boot = 1'b1;
    while (scan_busy !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    check("scan_busy", 32'(scan_busy), 32'h1);
    sys_boot = 1'b0;
    // type and sensor bytes take two cycles, settings follow one per cycle
    repeat (2) @(negedge core_clk);
    for (int i = 2; i <= 8; i++) begin
      @(negedge core_clk);
      check("cfg_valid", 32'(cfg_valid), 32'h1);
      check("cfg_sensor", 32'(cfg_sensor), 32'h42);
      check("cfg_index", 32'(cfg_index), 32'(i));
      check("cfg_value", 32'(cfg_value), 32'(i + 16));
    end
    @(negedge core_clk);
    check("cfg_valid", 32'(cfg_valid), 32'h0);
    repeat (8) @(negedge core_clk);
    for (int i = 2; i <= 4; i++) begin
      @(negedge core_clk);
      check("cfg_valid", 32'(cfg_valid), 32'h1);
      check("cfg_sensor", 32'(cfg_sensor), 32'h43);
      check("cfg_index", 32'(cfg_index), 32'(i));
      check("cfg_value", 32'(cfg_value), 32'(i + 32));
    end
    @(negedge core_clk);
    check("cfg_valid", 32'(cfg_valid), 32'h0);
    run(OP_TIME_GET, 12'h000, 32'h0, 1'b1);
  endtask

  initial begin
    reset = 1'b1;
    sys_boot = 1'b0;
    int_evt_valid = 1'b0;
    int_evt_data = 16'h0000;
    repeat (20) @(negedge core_clk);
    check("timestamp", timestamp, TS_RESET);
    check("scan_busy", 32'(scan_busy), 32'h1);
    reset = 1'b0;
    @(negedge core_clk);
    check("cmd_ready", 32'(cmd_ready), 32'h0);
    t_time();
    t_log();
    t_ranks();
    t_union();
    t_internal();
    t_expedite();
    t_boot();
    give_verdict();
  end
endmodule
